/* File: logic/io_port_remap.sv */
// General-purpose I/O port with remappable peripheral pin selection
//
// Operation
// - Per-pin open-drain enable
// - Per-pin weak pull-up and pull-down
// - Change on watched pin flags interrupt
// - Port keeps working in sleep and idle
// - Clear, set, invert aliases touch ones only; on CNSTAT set and invert clear every flag
// - Aliases at base plus 4, 8, 12
// - Remap only on fixed remappable pins
// - Inputs and outputs remapped at run time
// - Serial, timer, capture, compare, interrupts remapped
// - Two-wire and analog units never remapped
// - Remapped peripheral has no default pin
// - Fixed peripherals stay on default pin
// - Remapped peripheral overrides port and fixed peripherals
// - Priority same for every peripheral type
// - Analog function beats remapped peripheral
// - Separate input and output select registers
// - Input and output placed independently
// - Lock guards established mapping
// - Four-bit field selects pin per input
`timescale 1ns/1ps
module io_port_remap
	import io_remap_pkg::*;
#(
	parameter int PINS = PIN_N,
	parameter int IN_FNS = IN_FN_N
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [DATA_W-1:0] rdata_out,
	input wire logic sleep_in,
	input wire logic idle_in,
	input wire logic [PINS-1:0] pad_in,
	output logic [PINS-1:0] pad_out,
	output logic [PINS-1:0] pad_oe_out,
	output logic [PINS-1:0] pad_pu_out,
	output logic [PINS-1:0] pad_pd_out,
	input wire logic [PINS-1:0] analog_sel_in,
	input wire logic [PINS-1:0] fixed_en_in,
	input wire logic [PINS-1:0] fixed_out_in,
	input wire logic [PINS-1:0] fixed_oe_in,
	input wire logic [(1<<OUT_FN_W)-1:0] periph_out_in,
	input wire logic [(1<<OUT_FN_W)-1:0] periph_oe_in,
	output logic [IN_FNS-1:0] periph_in_out,
	output logic [IN_FNS-1:0] periph_in_valid_out,
	output logic change_irq_out
);
	logic [PINS-1:0] dir_q;
	logic [PINS-1:0] lat_q;
	logic [PINS-1:0] odc_q;
	logic [PINS-1:0] pu_q;
	logic [PINS-1:0] pd_q;
	logic [PINS-1:0] cnen_q;
	logic cn_on_q;
	logic cn_sidl_q;
	logic [PINS-1:0] cnstat;
	logic [SEL_W-1:0] in_sel_q [IN_FNS];
	logic [OUT_FN_W-1:0] out_sel_q [PINS];
	lock_state_t lock_q;
	logic [DATA_W-1:0] rdata_q;
	logic [ADDR_W-1:0] base;
	logic [3:0] alias_op;
	logic remap_open;
	logic cn_clear;
	logic cn_enable;
	logic [PINS-1:0] remap_active;
	logic [PINS-1:0] pin_level;
	logic [DATA_W-1:0] cncon_cur;
	logic [DATA_W-1:0] cncon_new;

	assign alias_op = addr_in[3:0];
	assign base = {addr_in[ADDR_W-1:4], 4'h0};
	assign remap_open = (lock_q == LK_OPEN);

	// Apply plain, clear, set or invert access to a register
	function automatic logic [DATA_W-1:0] alias_apply(input logic [DATA_W-1:0] cur,
		input logic [DATA_W-1:0] wd, input logic [3:0] op);
		logic [DATA_W-1:0] r;
		r = cur;
		case (op)
			ALIAS_PLAIN: r = wd;
			ALIAS_CLR: r = cur & ~wd;
			ALIAS_SET: r = cur | wd;
			ALIAS_FLIP: r = cur ^ wd;
			default: r = cur;
		endcase
		return r;
	endfunction : alias_apply

	function automatic logic [PINS-1:0] upd(input logic [PINS-1:0] cur,
		input logic [DATA_W-1:0] wd, input logic [3:0] op);
		logic [DATA_W-1:0] t;
		t = alias_apply(DATA_W'(cur), wd, op);
		return t[PINS-1:0];
	endfunction : upd

	// Control word view of the change-notice enables
	assign cncon_cur = (DATA_W'(cn_on_q) << CNCON_ON_BIT) | (DATA_W'(cn_sidl_q) << CNCON_SIDL_BIT);
	assign cncon_new = alias_apply(cncon_cur, wdata_in, alias_op);

	// Port control registers
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			dir_q <= RST_DIR[PINS-1:0];
			lat_q <= RST_ZERO[PINS-1:0];
			odc_q <= RST_ZERO[PINS-1:0];
			pu_q <= RST_ZERO[PINS-1:0];
			pd_q <= RST_ZERO[PINS-1:0];
			cnen_q <= RST_ZERO[PINS-1:0];
			cn_on_q <= 1'b0;
			cn_sidl_q <= 1'b0;
		end else if (wr_in) begin
			case (base)
				OFS_DIR: dir_q <= upd(dir_q, wdata_in, alias_op);
				OFS_PIN: lat_q <= upd(lat_q, wdata_in, alias_op);
				OFS_LAT: lat_q <= upd(lat_q, wdata_in, alias_op);
				OFS_ODC: odc_q <= upd(odc_q, wdata_in, alias_op);
				OFS_PU: pu_q <= upd(pu_q, wdata_in, alias_op);
				OFS_PD: pd_q <= upd(pd_q, wdata_in, alias_op);
				OFS_CNEN: cnen_q <= upd(cnen_q, wdata_in, alias_op);
				OFS_CNCON: begin
					cn_on_q <= cncon_new[CNCON_ON_BIT];
					cn_sidl_q <= cncon_new[CNCON_SIDL_BIT];
				end
				default: ;
			endcase
		end
	end

	// Remap lock: key write then open write; any other write to the lock register relocks
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			lock_q <= LK_LOCKED;
		end else if (wr_in && base == OFS_REMAP_LOCK) begin
			case (lock_q)
				LK_LOCKED: lock_q <= (wdata_in == UNLOCK_KEY) ? LK_KEYED : LK_LOCKED;
				LK_KEYED: lock_q <= (wdata_in == ~UNLOCK_KEY) ? LK_OPEN : LK_LOCKED;
				LK_OPEN: lock_q <= LK_LOCKED;
				default: lock_q <= LK_LOCKED;
			endcase
		end
	end

	// Separate input and output select sets, writable only while open
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < IN_FNS; i++) begin
				in_sel_q[i] <= SEL_NONE;
			end
			for (int j = 0; j < PINS; j++) begin
				out_sel_q[j] <= SEL_NONE;
			end
		end else if (wr_in && remap_open && alias_op == ALIAS_PLAIN) begin
			for (int i = 0; i < IN_FNS; i++) begin
				if (base == OFS_IN_SEL + ADDR_W'(i) * SEL_STRIDE) begin
					in_sel_q[i] <= wdata_in[SEL_W-1:0];
				end
			end
			for (int j = 0; j < PINS; j++) begin
				if (base == OFS_OUT_SEL + ADDR_W'(j) * SEL_STRIDE) begin
					out_sel_q[j] <= wdata_in[OUT_FN_W-1:0];
				end
			end
		end
	end

	// Pad drive priority: analog, remapped output, fixed peripheral, port
	always_comb begin
		for (int j = 0; j < PINS; j++) begin
			remap_active[j] = (out_sel_q[j] != SEL_NONE) && periph_oe_in[out_sel_q[j]];
			if (analog_sel_in[j]) begin
				pad_out[j] = 1'b0;
				pad_oe_out[j] = 1'b0;
			end else if (remap_active[j]) begin
				pad_out[j] = periph_out_in[out_sel_q[j]];
				pad_oe_out[j] = 1'b1;
			end else if (fixed_en_in[j]) begin
				pad_out[j] = fixed_out_in[j];
				pad_oe_out[j] = fixed_oe_in[j];
			end else begin
				pad_out[j] = odc_q[j] ? 1'b0 : lat_q[j];
				pad_oe_out[j] = ~dir_q[j] & ~(odc_q[j] & lat_q[j]);
			end
			pad_pu_out[j] = pu_q[j] & ~analog_sel_in[j];
			pad_pd_out[j] = pd_q[j] & ~analog_sel_in[j];
			pin_level[j] = analog_sel_in[j] ? 1'b0 : pad_in[j];
		end
	end

	// Input routing per peripheral input
	genvar g;
	generate
		for (g = 0; g < IN_FNS; g++) begin : g_in
			io_input_route #(.PINS(PINS)) u_route (
				.sel_in(in_sel_q[g]),
				.pins_in(pin_level),
				.routed_out(periph_in_out[g]),
				.valid_out(periph_in_valid_out[g])
			);
		end
	endgenerate

	// Change detection runs in sleep; idle stops it only with SIDL
	assign cn_enable = cn_on_q && !(idle_in && cn_sidl_q && !sleep_in);
	assign cn_clear = wr_in && base == OFS_CNSTAT;

	generate
		for (g = 0; g < PINS; g++) begin : g_cn
			io_change_detect u_cn (
				.clk_sys_in(clk_sys_in),
				.rst_in(rst_in),
				.enable_in(cn_enable),
				.watch_in(cnen_q[g]),
				.level_in(pin_level[g]),
				.clear_in(cn_clear && (alias_op == ALIAS_CLR ? wdata_in[g] : 1'b1)),
				.change_out(cnstat[g])
			);
		end
	endgenerate

	assign change_irq_out = |cnstat;

	// Read path, data one cycle after strobe
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			rdata_q <= RST_ZERO;
		end else if (rd_in) begin
			rdata_q <= RST_ZERO;
			case (base)
				OFS_DIR: rdata_q <= DATA_W'(dir_q);
				OFS_PIN: rdata_q <= DATA_W'(pin_level);
				OFS_LAT: rdata_q <= DATA_W'(lat_q);
				OFS_ODC: rdata_q <= DATA_W'(odc_q);
				OFS_PU: rdata_q <= DATA_W'(pu_q);
				OFS_PD: rdata_q <= DATA_W'(pd_q);
				OFS_CNEN: rdata_q <= DATA_W'(cnen_q);
				OFS_CNSTAT: rdata_q <= DATA_W'(cnstat);
				OFS_CNCON: rdata_q <= cncon_cur;
				OFS_REMAP_LOCK: rdata_q <= DATA_W'(remap_open);
				default: begin
					for (int i = 0; i < IN_FNS; i++) begin
						if (base == OFS_IN_SEL + ADDR_W'(i) * SEL_STRIDE) begin
							rdata_q <= DATA_W'(in_sel_q[i]);
						end
					end
					for (int j = 0; j < PINS; j++) begin
						if (base == OFS_OUT_SEL + ADDR_W'(j) * SEL_STRIDE) begin
							rdata_q <= DATA_W'(out_sel_q[j]);
						end
					end
				end
			endcase
		end
	end

	assign rdata_out = rdata_q;

	a_analog_wins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(analog_sel_in != '0) |-> ((pad_oe_out & analog_sel_in) == '0))
		else $error("analog pin driven");
	a_lock_blocks: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(wr_in && !remap_open) |=> (in_sel_q[0] == $past(in_sel_q[0])))
		else $error("locked select changed");
	a_set_alias: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(wr_in && base == OFS_LAT && alias_op == ALIAS_SET)
		|=> (lat_q == ($past(lat_q) | $past(wdata_in[PINS-1:0]))))
		else $error("set alias wrong");
	a_clr_alias: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(wr_in && base == OFS_ODC && alias_op == ALIAS_CLR)
		|=> (odc_q == ($past(odc_q) & ~$past(wdata_in[PINS-1:0]))))
		else $error("clear alias wrong");
	a_irq_follows: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		$fell(change_irq_out) |-> $past(cn_clear))
		else $error("irq dropped without clear");
	a_remap_over: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		((remap_active & ~analog_sel_in) != '0)
		|-> ((remap_active & ~analog_sel_in & ~pad_oe_out) == '0))
		else $error("remap not driving");
	a_od_no_high: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(odc_q[0] && !remap_active[0] && !fixed_en_in[0] && !analog_sel_in[0])
		|-> !(pad_oe_out[0] && pad_out[0]))
		else $error("open drain drove high");
	a_reset_clear: assert property (@(posedge clk_sys_in)
		$fell(rst_in) |-> (in_sel_q[0] == SEL_NONE && out_sel_q[0] == SEL_NONE))
		else $error("select not cleared");

	// Unlock steps: key, one cycle without lock write, inverted key
	sequence s_key_written;
		wr_in && base == OFS_REMAP_LOCK && wdata_in == UNLOCK_KEY && lock_q == LK_LOCKED;
	endsequence
	sequence s_lock_quiet;
		!(wr_in && base == OFS_REMAP_LOCK);
	endsequence
	sequence s_open_written;
		wr_in && base == OFS_REMAP_LOCK && wdata_in == ~UNLOCK_KEY;
	endsequence
	a_unlock_steps: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		s_key_written ##1 s_lock_quiet ##1 s_open_written |=> remap_open)
		else $error("unlock sequence failed");
endmodule : io_port_remap

/* File: logic/io_remap_pkg.sv */
// Package with offsets, field layouts and reset values for the remappable I/O port
package io_remap_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int PIN_N = 16;
	localparam int SEL_W = 4;
	localparam int OUT_FN_W = 4;
	localparam int IN_FN_N = 8;
	// Base offsets of port registers
	localparam logic [ADDR_W-1:0] OFS_DIR = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_PIN = 12'h010;
	localparam logic [ADDR_W-1:0] OFS_LAT = 12'h020;
	localparam logic [ADDR_W-1:0] OFS_ODC = 12'h030;
	localparam logic [ADDR_W-1:0] OFS_PU = 12'h040;
	localparam logic [ADDR_W-1:0] OFS_PD = 12'h050;
	localparam logic [ADDR_W-1:0] OFS_CNCON = 12'h060;
	localparam logic [ADDR_W-1:0] OFS_CNEN = 12'h070;
	localparam logic [ADDR_W-1:0] OFS_CNSTAT = 12'h080;
	localparam logic [ADDR_W-1:0] OFS_REMAP_LOCK = 12'h090;
	localparam logic [ADDR_W-1:0] OFS_IN_SEL = 12'h100;
	localparam logic [ADDR_W-1:0] OFS_OUT_SEL = 12'h200;
	localparam logic [ADDR_W-1:0] SEL_STRIDE = 12'h010;
	// Companion alias offsets
	localparam logic [3:0] ALIAS_PLAIN = 4'h0;
	localparam logic [3:0] ALIAS_CLR = 4'h4;
	localparam logic [3:0] ALIAS_SET = 4'h8;
	localparam logic [3:0] ALIAS_FLIP = 4'hc;
	// Field positions
	localparam int CNCON_ON_BIT = 15;
	localparam int CNCON_SIDL_BIT = 13;
	// Reset values
	localparam logic [DATA_W-1:0] RST_DIR = 32'h0000ffff;
	localparam logic [DATA_W-1:0] RST_ZERO = 32'h00000000;
	localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
	localparam logic [DATA_W-1:0] UNLOCK_KEY = 32'h0000a55a;
	typedef enum logic [1:0] {
		LK_LOCKED = 2'b00,
		LK_KEYED = 2'b01,
		LK_OPEN = 2'b11
	} lock_state_t;
endpackage : io_remap_pkg

/* File: logic/io_change_detect.sv */
// Per-pin change-of-state detector
`timescale 1ns/1ps
module io_change_detect
	import io_remap_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic enable_in,
	input wire logic watch_in,
	input wire logic level_in,
	input wire logic clear_in,
	output logic change_out
);
	logic last_q;
	logic flag_q;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			last_q <= 1'b0;
		end else begin
			last_q <= level_in;
		end
	end

	// Set wins over software clear
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			flag_q <= 1'b0;
		end else if (enable_in && watch_in && (level_in != last_q)) begin
			flag_q <= 1'b1;
		end else if (clear_in) begin
			flag_q <= 1'b0;
		end
	end

	assign change_out = flag_q;

	a_change_sets: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		(enable_in && watch_in && level_in != last_q) |=> change_out)
		else $error("change not flagged");
endmodule : io_change_detect

/* File: logic/io_input_route.sv */
// Input routing mux for one remapped peripheral input
`timescale 1ns/1ps
module io_input_route
	import io_remap_pkg::*;
#(
	parameter int PINS = PIN_N
) (
	input wire logic [SEL_W-1:0] sel_in,
	input wire logic [PINS-1:0] pins_in,
	output logic routed_out,
	output logic valid_out
);
	// Code 0 means unconnected; code k selects remappable pin k-1
	always_comb begin
		routed_out = 1'b0;
		valid_out = 1'b0;
		if (sel_in != SEL_NONE && 32'(sel_in) <= PINS) begin
			routed_out = pins_in[sel_in - 4'h1];
			valid_out = 1'b1;
		end
	end
endmodule : io_input_route

/* File: tb/pin_world_model.sv */
// Pin-side model: resolves each pad from port drive, external drive and pulls
`timescale 1ns/1ps
module pin_world_model #(
	parameter int PINS = 12
) (
	input wire logic clk_sys_in,
	input wire logic [PINS-1:0] pad_out_in,
	input wire logic [PINS-1:0] pad_oe_in,
	input wire logic [PINS-1:0] pu_in,
	input wire logic [PINS-1:0] pd_in,
	input wire logic [PINS-1:0] ext_level_in,
	input wire logic [PINS-1:0] ext_drive_in,
	output logic [PINS-1:0] pad_level_out
);
	// Floating pads show the inverse of the port value
	always_comb begin
		for (int i = 0; i < PINS; i++) begin
			if (pad_oe_in[i])
				pad_level_out[i] = pad_out_in[i];
			else if (ext_drive_in[i])
				pad_level_out[i] = ext_level_in[i];
			else if (pu_in[i] | pd_in[i])
				pad_level_out[i] = pu_in[i];
			else
				pad_level_out[i] = ~pad_out_in[i];
		end
	end
endmodule : pin_world_model

/* File: tb/tb_io_port_remap.sv */
// Self-checking bench for the remappable I/O port
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module tb_io_port_remap;
	import io_remap_pkg::*;
	localparam int P = 12;
	logic clk_sys_in, rst_in, wr_in, rd_in, sleep_in, idle_in, irq;
	logic [ADDR_W-1:0] addr_in;
	logic [DATA_W-1:0] wdata_in, rdata_out, v;
	logic [P-1:0] pad_in, pad_out, pad_oe, pu, pd, analog, fen, fout, foe, ext, extd, pat;
	logic [15:0] pout, poe;
	logic [IN_FN_N-1:0] pin_o, pin_v;
	logic [ADDR_W-1:0] regs [4] = '{OFS_LAT, OFS_ODC, OFS_PU, OFS_PD};
	int miscompares, tests_run;
	io_port_remap #(.PINS(P), .IN_FNS(IN_FN_N)) u_io_port_remap (
		.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sleep_in(sleep_in),
		.idle_in(idle_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_out(pad_oe),
		.pad_pu_out(pu), .pad_pd_out(pd), .analog_sel_in(analog), .fixed_en_in(fen),
		.fixed_out_in(fout), .fixed_oe_in(foe), .periph_out_in(pout), .periph_oe_in(poe),
		.periph_in_out(pin_o), .periph_in_valid_out(pin_v), .change_irq_out(irq));
	pin_world_model #(.PINS(P)) u_pin_world_model (.clk_sys_in(clk_sys_in),
		.pad_out_in(pad_out), .pad_oe_in(pad_oe), .pu_in(pu), .pd_in(pd),
		.ext_level_in(ext), .ext_drive_in(extd), .pad_level_out(pad_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #2 clk_sys_in = ~clk_sys_in;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 v = rdata_out;
	endtask : rd
	task automatic chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		rd(a);
		`CHK(v, e)
	endtask : chk
	task automatic wait_irq;
		for (int n = 0; n < 8 && irq !== 1'b1; n++) @(negedge clk_sys_in);
	endtask : wait_irq
	task automatic finish_test;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		#40000;
		miscompares++;
		finish_test();
	end
	initial begin
		{rst_in, wr_in, rd_in, sleep_in, idle_in} = 5'b10000;
		{addr_in, wdata_in, pout, poe, analog, fen, fout, foe, ext} = '0;
		extd = '1;
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		@(negedge clk_sys_in);
		`CHK(pad_oe, 12'h000)
		`CHK(pin_v, 8'h00)
		chk(OFS_OUT_SEL, 32'h0);
		chk(OFS_IN_SEL, 32'h0);
		chk(12'h0f0, 32'h0);
		foreach (regs[k]) begin
			wr(regs[k], 32'h0f0);
			wr(regs[k] + ALIAS_SET, 32'h00f);
			wr(regs[k] + ALIAS_CLR, 32'h003);
			wr(regs[k] + ALIAS_FLIP, 32'hf00);
			chk(regs[k], 32'hffc);
		end
		@(negedge clk_sys_in);
		`CHK(pu, 12'hffc)
		`CHK(pd, 12'hffc)
		wr(OFS_PU, 32'h0);
		wr(OFS_PD, 32'h0);
		wr(OFS_LAT, 32'h0a5);
		wr(OFS_ODC, 32'h003);
		wr(OFS_DIR, 32'h0);
		@(negedge clk_sys_in);
		`CHK(pad_oe, 12'hffe)
		`CHK(pad_out & 12'hffe, 12'h0a4)
		@(posedge clk_sys_in);
		{fen, fout, foe} <= {3{12'h008}};
		@(negedge clk_sys_in);
		`CHK({pad_out[3], pad_oe[3]}, 2'b11)
		wr(OFS_OUT_SEL + 12'h030, 32'h5);
		chk(OFS_OUT_SEL + 12'h030, 32'h0);
		wr(OFS_REMAP_LOCK, UNLOCK_KEY);
		wr(OFS_REMAP_LOCK, 32'hffff5aa5);
		rd(OFS_REMAP_LOCK);
		`CHK(v[0], 1'b1)
		@(posedge clk_sys_in);
		fout <= '0;
		for (int f = 1; f < 16; f++) begin
			wr(OFS_OUT_SEL + 12'h030, 32'(f));
			pout <= 16'h1 << f;
			poe <= 16'h1 << f;
			@(negedge clk_sys_in);
			`CHK({pad_out[3], pad_oe[3]}, 2'b11)
		end
		wr(OFS_OUT_SEL + 12'h030 + ALIAS_SET, 32'h1);
		chk(OFS_OUT_SEL + 12'h030, 32'hf);
		@(posedge clk_sys_in);
		analog <= 12'h008;
		@(negedge clk_sys_in);
		`CHK(pad_oe[3], 1'b0)
		@(posedge clk_sys_in);
		analog <= '0;
		wr(OFS_OUT_SEL + 12'h030, 32'h0);
		fen <= '0;
		wr(OFS_DIR + ALIAS_SET, 32'hfff);
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_sys_in);
			pat = p ? 12'h5a5 : 12'ha5a;
			ext <= pat;
			for (int i = 0; i < 8 && p == 0; i++) wr(OFS_IN_SEL + 12'(16 * i), 32'(i + 5));
			repeat (3) @(negedge clk_sys_in);
			`CHK(pin_o, pat[11:4])
			`CHK(pin_v, 8'hff)
		end
		wr(OFS_IN_SEL, 32'hd);
		wr(OFS_IN_SEL + 12'h010, 32'h0);
		@(negedge clk_sys_in);
		`CHK(pin_v, 8'hfc)
		wr(OFS_REMAP_LOCK, 32'h0);
		wr(OFS_IN_SEL + 12'h020, 32'h1);
		chk(OFS_IN_SEL + 12'h020, 32'h7);
		wr(OFS_IN_SEL, 32'h1);
		chk(OFS_IN_SEL, 32'hd);
		wr(OFS_CNCON, 32'h8000);
		wr(OFS_CNEN, 32'h040);
		wr(OFS_CNSTAT, 32'h0);
		ext <= ext ^ 12'h080;
		repeat (6) @(negedge clk_sys_in);
		`CHK(irq, 1'b0)
		@(posedge clk_sys_in);
		ext <= ext ^ 12'h040;
		wait_irq();
		`CHK(irq, 1'b1)
		rd(OFS_CNSTAT);
		`CHK(v[6], 1'b1)
		wr(OFS_CNSTAT, 32'h0);
		@(negedge clk_sys_in);
		`CHK(irq, 1'b0)
		@(posedge clk_sys_in);
		{sleep_in, idle_in} <= 2'b11;
		ext <= ext ^ 12'h040;
		wait_irq();
		`CHK(irq, 1'b1)
		wr(OFS_CNSTAT, 32'h0);
		wr(OFS_CNCON + ALIAS_SET, 32'h2000);
		sleep_in <= 1'b0;
		ext <= ext ^ 12'h040;
		repeat (6) @(negedge clk_sys_in);
		`CHK(irq, 1'b0)
		chk(OFS_CNCON, 32'ha000);
		finish_test();
	end
endmodule : tb_io_port_remap
